// [dv/dcwa_conv_src.sv]
`timescale 1ns/10ps
module dcwa_conv_src (
    input wire logic clk_sys_i,
    output dcwa_pkg::dcwa_conv_s conv_o
);
    import dcwa_pkg::*;

    initial begin
        conv_o = '0;
    end

    // ------------------------------------------------------------
    // One result pair per completed conversion
    // ------------------------------------------------------------
    task send(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk_sys_i);
        conv_o <= '{1'b1, a, b};
        @(posedge clk_sys_i);
        // Stale results are scrambled so a design that ignores valid gets caught
        conv_o <= '{1'b0, ~a, ~b};
    endtask
endmodule

// [dv/tb_dcwa_window_alert.sv]
`timescale 1ns/10ps
module tb_dcwa_window_alert;
    import dcwa_pkg::*;

`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin n_errors++; \
    $display("CHECK FAILED %0t got %0h exp %0h", $time, g, x); end end

    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    dcwa_apb_req_s apb = '0;
    dcwa_conv_s conv;
    logic pready;
    logic pslverr;
    logic sdo;
    logic irq;
    logic [31:0] prdata;
    logic [31:0] d;
    logic e;
    logic [31:0] r;
    logic [5:0] fl;
    logic [5:0] ist;
    logic [5:0] ien;
    int lo;
    int hi;
    int n_errors = 0;
    int total_checks = 0;
    integer seed;

    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    dcwa_window_alert i_dcwa_window_alert (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .apb_i(apb),
        .pready_o(pready),
        .pslverr_o(pslverr),
        .prdata_o(prdata),
        .conv_i(conv),
        .sdo_one_wire_o(sdo),
        .irq_o(irq)
    );

    dcwa_conv_src u_src (
        .clk_sys_i(clk_sys_i),
        .conv_o(conv)
    );

    task wrap_up;
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // APB master
    // ------------------------------------------------------------
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
              output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk_sys_i);
        apb <= '{1'b1, 1'b0, w, a, wd};
        @(posedge clk_sys_i);
        apb.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            wrap_up;
        end
        rd = prdata;
        er = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask

    // Data carries its own index in bits 15 to 12, as every write must
    task wr(input logic [3:0] i, input logic [11:0] v);
        xfer(1'b1, {6'h0, i, 2'b00}, {16'h0, i, v}, d, e);
        `CHK(e, 1'b0)
    endtask

    task rchk(input logic [3:0] i, input logic [31:0] x);
        xfer(1'b0, {6'h0, i, 2'b00}, 32'h0, d, e);
        `CHK(d, x)
    endtask

    // Reading the alert register empties the model's flags as well
    task ral;
        rchk(4'h3, {16'h0, 4'h3, 6'h0, fl});
        fl = '0;
    endtask

    task cv(input logic [15:0] a, input logic [15:0] b);
        logic [5:0] ev;
        ev = {b > hi * 16 + 15, b < lo * 16, 2'b00, a > hi * 16 + 15, a < lo * 16};
        u_src.send(a, b);
        fl = fl | ev;
        ist = ist | ev;
        @(negedge clk_sys_i);
        `CHK(irq, |(ist & ien))
    endtask

    initial begin
        repeat (90000) @(posedge clk_sys_i);
        n_errors++;
        wrap_up;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'heac728a2;
        lo = 12'h800;
        hi = 12'h7ff;
        fl = '0;
        ist = '0;
        ien = '0;
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rchk(4'h4, 32'h4800);
        rchk(4'h5, 32'h57ff);
        rchk(4'h3, 32'h3000);
        wr(4'h8, 12'h033);
        ien = 6'h33;
        wr(4'h4, 12'h123);
        lo = 12'h123;
        wr(4'h5, 12'hcde);
        hi = 12'hcde;
        cv(16'h122f, 16'h1230);
        ral();
        ral();
        cv(16'hcdef, 16'hcdf0);
        cv(16'h5000, 16'h5000);
        ral();
        cv(16'h1230, 16'h122f);
        ral();
        for (int k = 0; k < 40; k++) begin
            if (k % 8 == 0) begin
                lo = $random(seed) & 12'hfff;
                hi = $random(seed) & 12'hfff;
                wr(4'h4, lo[11:0]);
                wr(4'h5, hi[11:0]);
            end
            r = $random(seed);
            cv(r[15:0], r[31:16]);
            if (k % 3 == 0)
                ral();
        end
        ral();
        rchk(4'h6, {16'h0, 4'h6, 6'h0, ist});
        wr(4'h7, {6'h0, ist});
        ist = '0;
        @(negedge clk_sys_i);
        `CHK(irq, 1'b0)
        wr(4'h8, 12'h000);
        ien = '0;
        cv(16'h0000, 16'hffff);
        xfer(1'b1, 12'h00c, 32'h0000_3033, d, e);
        `CHK(e, 1'b1)
        rchk(4'h6, {16'h0, 4'h6, 6'h0, ist});
        wr(4'h2, 12'h03c);
        fl = '0;
        ral();
        rchk(4'h4, {16'h0, 4'h4, lo[11:0]});
        xfer(1'b1, 12'h010, 32'h0000_5abc, d, e);
        `CHK(e, 1'b1)
        rchk(4'h4, {16'h0, 4'h4, lo[11:0]});
        xfer(1'b0, 12'h024, 32'h0, d, e);
        `CHK(e, 1'b1)
        `CHK(d, 32'h0)
        xfer(1'b0, 12'h011, 32'h0, d, e);
        `CHK(e, 1'b1)
        `CHK(d, 32'h0)
        wr(4'h2, 12'h100);
        @(negedge clk_sys_i);
        `CHK(sdo, 1'b1)
        wr(4'h2, 12'h0ff);
        lo = 12'h800;
        hi = 12'h7ff;
        @(negedge clk_sys_i);
        `CHK(sdo, 1'b0)
        rchk(4'h4, 32'h4800);
        rchk(4'h5, 32'h57ff);
        wrap_up;
    end
endmodule

// [src/dcwa_defs.svh]
`ifndef DCWA_DEFS_SVH
`define DCWA_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DCWA_IDX_CFG2 4'h2
`define DCWA_IDX_ALERT 4'h3
`define DCWA_IDX_LOW 4'h4
`define DCWA_IDX_HIGH 4'h5
`define DCWA_IDX_IRQ_STAT 4'h6
`define DCWA_IDX_IRQ_CLR 4'h7
`define DCWA_IDX_IRQ_EN 4'h8

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define DCWA_TAG_HI 15
`define DCWA_TAG_LO 12
`define DCWA_SDO_BIT 8
`define DCWA_BIT_A_UNDER 0
`define DCWA_BIT_A_OVER 1
`define DCWA_BIT_B_UNDER 4
`define DCWA_BIT_B_OVER 5
`define DCWA_FLAG_MASK 6'h33

// ----------------------------------------------------------------
// Reset values and commands
// ----------------------------------------------------------------
`define DCWA_LOW_RST 12'h800
`define DCWA_HIGH_RST 12'h7ff
`define DCWA_LO_PAD 4'h0
`define DCWA_HI_PAD 4'hf
`define DCWA_SOFT_RST 8'h3c
`define DCWA_HARD_RST 8'hff

`endif

// [src/dcwa_irq.sv]
`timescale 1ns/10ps
`include "dcwa_defs.svh"
module dcwa_irq (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire dcwa_pkg::dcwa_flags_t evt_i,
    input wire logic clr_we_i,
    input wire logic en_we_i,
    input wire dcwa_pkg::dcwa_flags_t wdata_i,
    output dcwa_pkg::dcwa_flags_t stat_o,
    output dcwa_pkg::dcwa_flags_t en_o,
    output logic irq_o
);
    import dcwa_pkg::*;

    dcwa_irq_state_s st_ff;
    dcwa_irq_state_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // New events win over a clear in the same cycle
        nxt_st.stat = (st_ff.stat & ~(clr_we_i ? wdata_i : '0)) | evt_i;
        if (en_we_i) begin
            nxt_st.en = wdata_i & `DCWA_FLAG_MASK;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign stat_o = st_ff.stat;
    assign en_o = st_ff.en;
    assign irq_o = |(st_ff.stat & st_ff.en);

    a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        irq_o == |(stat_o & en_o)) else $error("irq level wrong");
    a_irq_event: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        |evt_i |=> (stat_o & $past(evt_i)) == $past(evt_i))
        else $error("irq event lost");
endmodule

// [src/dcwa_pkg.sv]
package dcwa_pkg;
`include "dcwa_defs.svh"

    typedef struct packed {
        logic valid;
        logic [15:0] res_a;
        logic [15:0] res_b;
    } dcwa_conv_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dcwa_apb_req_s;

    typedef logic [5:0] dcwa_flags_t;

    typedef struct packed {
        logic [11:0] lower;
        logic [11:0] upper;
        logic sdo;
        dcwa_flags_t flags;
        dcwa_flags_t rd_mask;
        logic [31:0] rdata;
    } dcwa_state_s;

    typedef struct packed {
        dcwa_flags_t stat;
        dcwa_flags_t en;
    } dcwa_irq_state_s;

    function automatic logic [15:0] dcwa_widen_lo(input logic [11:0] f);
        return {f, `DCWA_LO_PAD};
    endfunction

    function automatic logic [15:0] dcwa_widen_hi(input logic [11:0] f);
        return {f, `DCWA_HI_PAD};
    endfunction
endpackage

// [src/dcwa_win_cmp.sv]
`timescale 1ns/10ps
module dcwa_win_cmp (
    input wire logic valid_i,
    input wire logic [15:0] result_i,
    input wire logic [11:0] lower_i,
    input wire logic [11:0] upper_i,
    output logic under_o,
    output logic over_o
);
    import dcwa_pkg::*;

    always_comb begin
        under_o = valid_i && (result_i < dcwa_widen_lo(lower_i));
        over_o = valid_i && (result_i > dcwa_widen_hi(upper_i));
    end
endmodule

// [src/dcwa_window_alert.sv]
// Functional notes
// - A channel A result above the upper limit sets the channel A over flag.
// - A channel A result below the lower limit sets the channel A under flag at bit 0.
// - Limit flags are sticky and clear only when software reads the alert register or writes the soft (0x3c) or hard (0xff) reset command.
// - The 12-bit lower field is widened to 16 bits with a low nibble of zero.
// - The 12-bit upper field is widened to 16 bits with a low nibble of all ones.
// - The lower check alerts for results below the widened lower limit only.
// - The upper check alerts for results above the widened upper limit only.
// - Bits 15 to 12 of every register word carry that register's own index.
// - The lower-limit register at index 4 resets to 0x0800.
// - The upper-limit register at index 5 resets to 0x07ff.
// - A channel B over flag sits at bit 5 and is sticky and clear-on-read.
// - A channel B under flag is set by channel B results and is sticky until read.
// - Writing 0x3c to the reset field clears all alert flags and keeps the limits.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
`include "dcwa_defs.svh"
module dcwa_window_alert (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire dcwa_pkg::dcwa_apb_req_s apb_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o,
    input wire dcwa_pkg::dcwa_conv_s conv_i,
    output logic sdo_one_wire_o,
    output logic irq_o
);
    import dcwa_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    dcwa_state_s st_ff;
    dcwa_state_s nxt_st;
    logic a_under;
    logic a_over;
    logic b_under;
    logic b_over;
    dcwa_flags_t set_vec;
    dcwa_flags_t irq_stat;
    dcwa_flags_t irq_en;
    logic [3:0] idx;
    logic addr_ok;
    logic ro_reg;
    logic tag_ok;
    logic setup;
    logic access;
    logic err;
    logic wr;
    logic rd_alert;
    logic cfg_wr;
    logic soft_rst;
    logic hard_rst;
    logic irq_clr_we;
    logic irq_en_we;
    logic [31:0] rd_val;

    // ----------------------------------------------------------------
    // Window comparators, one per channel
    // ----------------------------------------------------------------
    dcwa_win_cmp u_cmp_a (
        .valid_i(conv_i.valid),
        .result_i(conv_i.res_a),
        .lower_i(st_ff.lower),
        .upper_i(st_ff.upper),
        .under_o(a_under),
        .over_o(a_over)
    );

    dcwa_win_cmp u_cmp_b (
        .valid_i(conv_i.valid),
        .result_i(conv_i.res_b),
        .lower_i(st_ff.lower),
        .upper_i(st_ff.upper),
        .under_o(b_under),
        .over_o(b_over)
    );

    always_comb begin
        set_vec = '0;
        set_vec[`DCWA_BIT_A_UNDER] = a_under;
        set_vec[`DCWA_BIT_A_OVER] = a_over;
        set_vec[`DCWA_BIT_B_UNDER] = b_under;
        set_vec[`DCWA_BIT_B_OVER] = b_over;
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign idx = apb_i.paddr[5:2];
    assign setup = apb_i.psel && !apb_i.penable;
    assign access = apb_i.psel && apb_i.penable;

    always_comb begin
        addr_ok = (apb_i.paddr[1:0] == 2'h0) && (apb_i.paddr[11:6] == 6'h00)
            && (idx >= `DCWA_IDX_CFG2) && (idx <= `DCWA_IDX_IRQ_EN);
        ro_reg = (idx == `DCWA_IDX_ALERT) || (idx == `DCWA_IDX_IRQ_STAT);
        // A write whose tag names another register is refused
        tag_ok = (apb_i.pwdata[`DCWA_TAG_HI:`DCWA_TAG_LO] == idx);
        err = access && (!addr_ok || (apb_i.pwrite && (ro_reg || !tag_ok)));
        wr = access && apb_i.pwrite && !err;
        rd_alert = access && !apb_i.pwrite && !err && (idx == `DCWA_IDX_ALERT);
        cfg_wr = wr && (idx == `DCWA_IDX_CFG2);
        soft_rst = cfg_wr && (apb_i.pwdata[7:0] == `DCWA_SOFT_RST);
        hard_rst = cfg_wr && (apb_i.pwdata[7:0] == `DCWA_HARD_RST);
        irq_clr_we = wr && (idx == `DCWA_IDX_IRQ_CLR);
        irq_en_we = wr && (idx == `DCWA_IDX_IRQ_EN);
    end

    // Zero wait states: every access phase completes at once
    assign pready_o = 1'b1;
    assign pslverr_o = err;

    // ----------------------------------------------------------------
    // Read mux, sampled in the setup cycle
    // ----------------------------------------------------------------
    always_comb begin
        rd_val = '0;
        case (idx)
            `DCWA_IDX_CFG2: begin
                rd_val[`DCWA_SDO_BIT] = st_ff.sdo;
            end
            `DCWA_IDX_ALERT: begin
                rd_val[5:0] = st_ff.flags;
            end
            `DCWA_IDX_LOW: begin
                rd_val[11:0] = st_ff.lower;
            end
            `DCWA_IDX_HIGH: begin
                rd_val[11:0] = st_ff.upper;
            end
            `DCWA_IDX_IRQ_STAT: begin
                rd_val[5:0] = irq_stat;
            end
            `DCWA_IDX_IRQ_EN: begin
                rd_val[5:0] = irq_en;
            end
            default: begin
                rd_val = '0;
            end
        endcase
        if (addr_ok) begin
            rd_val[`DCWA_TAG_HI:`DCWA_TAG_LO] = idx;
        end else begin
            rd_val = '0;
        end
    end

    // ----------------------------------------------------------------
    // State update
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (setup) begin
            nxt_st.rdata = rd_val;
            nxt_st.rd_mask = rd_val[5:0];
        end
        // Only the bits software actually saw are cleared by the read,
        // so an event landing between setup and access is not lost
        nxt_st.flags = st_ff.flags & ~(rd_alert ? st_ff.rd_mask : '0);
        if (soft_rst || hard_rst) begin
            nxt_st.flags = '0;
        end
        // A new event always wins over any clear
        nxt_st.flags = nxt_st.flags | set_vec;
        if (wr && (idx == `DCWA_IDX_LOW)) begin
            nxt_st.lower = apb_i.pwdata[11:0];
        end
        if (wr && (idx == `DCWA_IDX_HIGH)) begin
            nxt_st.upper = apb_i.pwdata[11:0];
        end
        if (cfg_wr && !soft_rst) begin
            nxt_st.sdo = apb_i.pwdata[`DCWA_SDO_BIT];
        end
        if (hard_rst) begin
            nxt_st.lower = `DCWA_LOW_RST;
            nxt_st.upper = `DCWA_HIGH_RST;
            nxt_st.sdo = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff.lower <= `DCWA_LOW_RST;
            st_ff.upper <= `DCWA_HIGH_RST;
            st_ff.sdo <= 1'b0;
            st_ff.flags <= '0;
            st_ff.rd_mask <= '0;
            st_ff.rdata <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata_o = st_ff.rdata;
    assign sdo_one_wire_o = st_ff.sdo;

    // ----------------------------------------------------------------
    // Interrupt status, clear and enable
    // ----------------------------------------------------------------
    dcwa_irq u_irq (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .evt_i(set_vec),
        .clr_we_i(irq_clr_we),
        .en_we_i(irq_en_we),
        .wdata_i(apb_i.pwdata[5:0]),
        .stat_o(irq_stat),
        .en_o(irq_en),
        .irq_o(irq_o)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    logic first_ff;
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            first_ff <= 1'b1;
        end else begin
            first_ff <= 1'b0;
        end
    end

    a_a_over_set: assert property (
        conv_i.valid && (conv_i.res_a > dcwa_widen_hi(st_ff.upper))
        |=> st_ff.flags[`DCWA_BIT_A_OVER])
        else $error("channel A over flag not set");

    a_a_under_set: assert property (
        conv_i.valid && (conv_i.res_a < dcwa_widen_lo(st_ff.lower))
        |=> st_ff.flags[`DCWA_BIT_A_UNDER])
        else $error("channel A under flag not set");

    a_flag_sticky: assert property (
        !rd_alert && !cfg_wr |=> (st_ff.flags & $past(st_ff.flags)) == $past(st_ff.flags))
        else $error("alert flag dropped without read");

    a_read_clears: assert property (
        rd_alert && !conv_i.valid && (st_ff.rd_mask == st_ff.flags)
        |=> st_ff.flags == '0)
        else $error("alert read did not clear flags");

    a_lo_edge_quiet: assert property (
        conv_i.valid && (conv_i.res_a == dcwa_widen_lo(st_ff.lower))
        && !st_ff.flags[`DCWA_BIT_A_UNDER] && !rd_alert && !cfg_wr
        |=> !st_ff.flags[`DCWA_BIT_A_UNDER])
        else $error("lower limit itself raised an alert");

    a_hi_edge_quiet: assert property (
        conv_i.valid && (conv_i.res_a == dcwa_widen_hi(st_ff.upper))
        && !st_ff.flags[`DCWA_BIT_A_OVER] && !rd_alert && !cfg_wr
        |=> !st_ff.flags[`DCWA_BIT_A_OVER])
        else $error("upper limit itself raised an alert");

    a_tag_read: assert property (
        setup && !apb_i.pwrite && addr_ok
        |=> prdata_o[`DCWA_TAG_HI:`DCWA_TAG_LO] == $past(idx))
        else $error("read word lacks its register index");

    a_limit_reset: assert property (
        first_ff |-> (st_ff.lower == `DCWA_LOW_RST) && (st_ff.upper == `DCWA_HIGH_RST))
        else $error("limit registers not at reset values");

    a_b_over_set: assert property (
        conv_i.valid && (conv_i.res_b > dcwa_widen_hi(st_ff.upper))
        |=> st_ff.flags[`DCWA_BIT_B_OVER])
        else $error("channel B over flag not set");

    a_b_under_set: assert property (
        conv_i.valid && (conv_i.res_b < dcwa_widen_lo(st_ff.lower))
        |=> st_ff.flags[`DCWA_BIT_B_UNDER])
        else $error("channel B under flag not set");

    a_soft_clear: assert property (
        soft_rst && !conv_i.valid
        |=> (st_ff.flags == '0) && $stable(st_ff.lower) && $stable(st_ff.upper))
        else $error("soft reset misbehaved");

    a_no_conv_set: assert property (
        !conv_i.valid |=> (st_ff.flags & ~$past(st_ff.flags)) == '0)
        else $error("flag set without a conversion");

    a_tag_write: assert property (
        access && apb_i.pwrite && !tag_ok |-> pslverr_o)
        else $error("mistagged write not refused");

    // A mistagged write must leave the lower and upper limits and the SDO bit as they were
    a_bad_write_quiet: assert property (
        access && apb_i.pwrite && !tag_ok
        |=> $stable(st_ff.lower) && $stable(st_ff.upper) && $stable(st_ff.sdo))
        else $error("mistagged write changed a register");

    a_ro_refused: assert property (
        access && apb_i.pwrite && ro_reg |-> pslverr_o)
        else $error("write to read-only register not refused");

    a_unmapped_zero: assert property (
        setup && !addr_ok |=> prdata_o == '0)
        else $error("unmapped read returned data");

    a_read_value: assert property (
        setup && !apb_i.pwrite && addr_ok && (idx == `DCWA_IDX_ALERT)
        |=> prdata_o[5:0] == $past(st_ff.flags))
        else $error("alert read returned wrong flags");

    // Read data stands from the edge after setup until the next setup
    a_rd_hold: assert property (
        !setup |=> $stable(prdata_o))
        else $error("read data moved outside a setup cycle");

    // Channel B is checked over the whole quiet side, not only at the edge
    a_b_lo_quiet: assert property (
        conv_i.valid && (conv_i.res_b >= dcwa_widen_lo(st_ff.lower))
        && !st_ff.flags[`DCWA_BIT_B_UNDER] && !rd_alert && !cfg_wr
        |=> !st_ff.flags[`DCWA_BIT_B_UNDER])
        else $error("channel B under flag set inside the window");

    a_b_hi_quiet: assert property (
        conv_i.valid && (conv_i.res_b <= dcwa_widen_hi(st_ff.upper))
        && !st_ff.flags[`DCWA_BIT_B_OVER] && !rd_alert && !cfg_wr
        |=> !st_ff.flags[`DCWA_BIT_B_OVER])
        else $error("channel B over flag set inside the window");

    a_set_beats_clear: assert property (
        rd_alert && (set_vec != '0)
        |=> (st_ff.flags & $past(set_vec)) == $past(set_vec))
        else $error("event lost in a clearing read");

    a_soft_keeps_cfg: assert property (
        soft_rst |=> $stable(st_ff.sdo))
        else $error("soft reset changed the configuration");

    a_hard_limits: assert property (
        hard_rst |=> (st_ff.lower == `DCWA_LOW_RST) && (st_ff.upper == `DCWA_HIGH_RST))
        else $error("hard reset left the limits changed");

    c_a_over: cover property (conv_i.valid ##1 st_ff.flags[`DCWA_BIT_A_OVER]);
    c_read_clear: cover property (rd_alert && (st_ff.flags != '0) ##1 st_ff.flags == '0);
    c_soft_rst: cover property (soft_rst && (st_ff.flags != '0));
    c_irq: cover property (irq_o);
    c_b_under: cover property (conv_i.valid && b_under ##1 st_ff.flags[`DCWA_BIT_B_UNDER]);
endmodule
